// ---- src/tdmtx_defines.svh ----
// Constants for the TDM slot transmitter: offsets, fields, resets and timing
`ifndef TDMTX_DEFINES_SVH
`define TDMTX_DEFINES_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define TDMTX_ADDR_CTRL 12'h000
`define TDMTX_ADDR_STATUS 12'h004
`define TDMTX_ADDR_CHAN_CFG 12'h008
`define TDMTX_ADDR_SLOT_COUNT 12'h00C
`define TDMTX_ADDR_SLOT_EN_LO 12'h010
`define TDMTX_ADDR_SLOT_EN_HI 12'h014
`define TDMTX_ADDR_DATA0 12'h020

// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define TDMTX_CTRL_MASTER 0
`define TDMTX_CTRL_EARLY 1
`define TDMTX_CTRL_SYNC_EN 2
`define TDMTX_CTRL_LPD 3
`define TDMTX_CTRL_ULPD 4
`define TDMTX_STAT_SYNC_DONE 0
`define TDMTX_STAT_FRAME_RUN 1
`define TDMTX_CFG_STATE_BIT 6
`define TDMTX_COUNT_RESET 12'h333
`define TDMTX_SLOT_EN_RESET 48'hFFFF_FFFF_FFFF

// ---------------------------------------------------------------
// Frame geometry
// ---------------------------------------------------------------
`define TDMTX_CHANS 4
`define TDMTX_DATA_W 24
`define TDMTX_WINDOW_BITS 11'd384
`define TDMTX_TAIL_END 11'd400
`define TDMTX_LAST_HANDOFF 11'd376

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define TDMTX_CLK_MHZ 200
`define TDMTX_BCLK_HALF_NS 10
`define TDMTX_BCLK_HALF_CYC (((`TDMTX_BCLK_HALF_NS) * (`TDMTX_CLK_MHZ) + 999) / 1000)
`define TDMTX_SYNC_PULSE_NS 100
`define TDMTX_SYNC_PULSE_CYC (((`TDMTX_SYNC_PULSE_NS) * (`TDMTX_CLK_MHZ) + 999) / 1000)

`endif

// ---- src/tdmtx_pkg.sv ----
// Types shared by the TDM slot transmitter modules
`default_nettype none

package tdmtx_pkg;
    // Position of a bit within the frame
    typedef logic [10:0] tdmtx_pos_t;
    // Frame shifting phase
    typedef enum logic [1:0] {PH_IDLE, PH_ARMED, PH_RUN} tdmtx_phase_t;
    // Multichip sync initiator phase
    typedef enum logic [1:0] {SY_IDLE, SY_PULSE, SY_HOLD} tdmtx_sync_t;
endpackage

`default_nettype wire

// ---- src/tdmtx_slot_map.sv ----
// Channel-to-slot mapper: picks the owning channel and the bit for a frame position
`default_nettype none
`include "tdmtx_defines.svh"

module tdmtx_slot_map (
    input wire tdmtx_pkg::tdmtx_pos_t bitPos,
    input wire logic [23:0] startSlot,
    input wire logic [3:0] txState,
    input wire logic [11:0] slotCount,
    input wire logic [95:0] sample,
    output logic hit,
    output logic bitVal
);
    import tdmtx_pkg::*;

    logic [7:0] slot;
    logic [7:0] bestStart;
    logic [1:0] best;
    logic [7:0] idx;
    logic [23:0] word;

    // ---------------------------------------------------------------
    // Owner selection
    // ---------------------------------------------------------------
    // Later start wins; a tie keeps the lower channel (strict compare)
    always_comb begin
        slot = {2'b00, bitPos[8:3]} | {bitPos[10:9], 6'b000000};
        hit = 1'b0;
        bestStart = 8'h00;
        best = 2'd0;
        for (int i = 0; i < `TDMTX_CHANS; i++) begin
            if (txState[i] && slot >= {2'b00, startSlot[6*i +: 6]} &&                       // [R4]
                slot < {2'b00, startSlot[6*i +: 6]} + {5'b00000, slotCount[3*i +: 3]}) begin // [R3]
                if (!hit || {2'b00, startSlot[6*i +: 6]} > bestStart) begin                // [R7] [R8]
                    hit = 1'b1;
                    bestStart = {2'b00, startSlot[6*i +: 6]};
                    best = 2'(i);
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Bit pick, MSB first
    // ---------------------------------------------------------------
    // Word is always the full 24-bit sample whatever its bus width
    always_comb begin
        word = sample[24*best +: 24]; // [R9]
        idx = {5'(slot - bestStart), 3'b000} | {5'b00000, bitPos[2:0]};
        if (idx < 8'(`TDMTX_DATA_W)) begin
            bitVal = word[5'(8'd23 - idx)]; // [R3] [R10]
        end else begin
            bitVal = 1'b0; // Zero fill past the sample [R11]
        end
    end
endmodule

`default_nettype wire

// ---- src/tdmtx_transmitter.sv ----
// TDM slot transmitter top: APB registers, bit clock, frame shifter, multichip sync
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`default_nettype none
`include "tdmtx_defines.svh"

// Behaviour
// R1 - As bit-clock slave, shift data only on incoming bit clock edges.
// R2 - As bit-clock master, keep the generated bit clock running all frame.
// R3 - Each channel starts at one of 48 slots, sent MSB first.
// R4 - A channel with transmit state cleared is never loaded into a slot.
// R5 - Only enabled loaded slots drive the serial data output.
// R6 - Disabled slots are high impedance; neighbouring enabled slots still send.
// R7 - Overlapping later-starting data set wins the shared slots.
// R8 - Same start slot: lowest-numbered channel wins.
// R9 - Each channel holds a full 24-bit transmit word.
// R10 - Short allocation sends upper bits, drops the low ones.
// R11 - Long allocation sends all 24 bits then zeros.
// R12 - Hand the line over within half a bit clock.
// R13 - Early-first-bit mode hands over with no margin.
// R14 - Last bit before a disabled slot releases half a clock early.
// R15 - After slot 47 drive at most 16 clocks, then low.
// R16 - Starts at slots 46 or 47 send all 24 bits, then low.
// R17 - Slot 47 disabled: high impedance until frame end.
// R18 - Seeing a completed sync pulse sets sync-done, initiator included.
// R19 - Controller powers and configures all, then enables sync on one initiator.
// R20 - Alternate order: initiator sync enable first, initiator powered last.
// R21 - First bit on second rising edge after frame sync; early moves half clock.
// R22 - Master bit clock is a plain copy rate from the core clock; here it is the core clock divided by 4.
// R23 - Slot and bit counters restart at every frame start.
// R24 - Channel words sampled once per frame before any slot.
module tdmtx_transmitter (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic bitClkIn,
    input wire logic frameSyncIn,
    input wire logic syncIn,
    output logic bitClkOut,
    output logic bitClkOe,
    output logic serialDataOut,
    output logic serialDataOe,
    output logic syncOut,
    output logic syncOe
);
    import tdmtx_pkg::*;

    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    logic masterMode;
    logic earlyFirstBit;
    logic syncEnable;
    logic lowPowerDown;
    logic ultraLowPowerDown;
    logic syncDone;
    logic [23:0] channelStartSlot;
    logic [3:0] channelTransmitState;
    logic [11:0] channelSlotCount;
    logic [47:0] slotTransmitEnable;
    logic [23:0] chanData [4];
    logic [95:0] sample;
    logic [2:0] pinMeta;
    logic [2:0] pinSync;
    logic bclkPrev;
    logic fsyncPrev;
    logic syncLowSeen;
    logic [2:0] divCnt;
    logic [4:0] syncCnt;
    tdmtx_sync_t syncPhase;
    tdmtx_phase_t phase;
    tdmtx_pos_t bitPos;
    tdmtx_pos_t shownPos;
    logic powered;
    logic bclkLevel;
    logic rise;
    logic fall;
    logic launch;
    logic midEdge;
    logic frameStart;
    logic apbSetup;
    logic apbWrite;
    logic [3:0] regSel;
    logic mapHit;
    logic mapBit;
    logic next_dataOe;
    logic next_dataOut;
    logic [5:0] nextSlot;

    // Register index from address; 4'hF marks an unmapped address
    function automatic logic [3:0] decodeReg(input logic [11:0] a);
        unique case (a)
            `TDMTX_ADDR_CTRL: decodeReg = 4'h0;
            `TDMTX_ADDR_STATUS: decodeReg = 4'h1;
            `TDMTX_ADDR_CHAN_CFG: decodeReg = 4'h2;
            `TDMTX_ADDR_SLOT_COUNT: decodeReg = 4'h3;
            `TDMTX_ADDR_SLOT_EN_LO: decodeReg = 4'h4;
            `TDMTX_ADDR_SLOT_EN_HI: decodeReg = 4'h5;
            `TDMTX_ADDR_DATA0: decodeReg = 4'h6;
            `TDMTX_ADDR_DATA0 + 12'h004: decodeReg = 4'h7;
            `TDMTX_ADDR_DATA0 + 12'h008: decodeReg = 4'h8;
            `TDMTX_ADDR_DATA0 + 12'h00C: decodeReg = 4'h9;
            default: decodeReg = 4'hF;
        endcase
    endfunction

    // ---------------------------------------------------------------
    // APB slave
    // ---------------------------------------------------------------
    // One wait state; the write lands on the edge that sees pready high
    assign apbSetup = psel && penable && !pready;
    assign apbWrite = psel && penable && pready && pwrite;
    assign regSel = decodeReg(paddr);
    assign powered = !lowPowerDown && !ultraLowPowerDown;

    // Handshake and read data
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= apbSetup;
            pslverr <= apbSetup && (regSel == 4'hF);
            prdata <= 32'h0000_0000;
            if (apbSetup && !pwrite) begin
                unique case (regSel)
                    4'h0: prdata <= {27'h0, ultraLowPowerDown, lowPowerDown, syncEnable, earlyFirstBit, masterMode};
                    4'h1: prdata <= {30'h0, phase == PH_RUN, syncDone};
                    4'h2: begin
                        for (int i = 0; i < `TDMTX_CHANS; i++) begin
                            prdata[8*i +: 7] <= {channelTransmitState[i], channelStartSlot[6*i +: 6]};
                        end
                    end
                    4'h3: begin
                        for (int i = 0; i < `TDMTX_CHANS; i++) begin
                            prdata[4*i +: 3] <= channelSlotCount[3*i +: 3];
                        end
                    end
                    4'h4: prdata <= slotTransmitEnable[31:0];
                    4'h5: prdata <= {16'h0000, slotTransmitEnable[47:32]};
                    4'h6, 4'h7, 4'h8, 4'h9: prdata <= {8'h00, chanData[2'(regSel - 4'h6)]};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Control, mapping and data registers
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            masterMode <= 1'b0;
            earlyFirstBit <= 1'b0;
            syncEnable <= 1'b0;
            lowPowerDown <= 1'b1;
            ultraLowPowerDown <= 1'b1;
            channelStartSlot <= 24'h000000;
            channelTransmitState <= 4'h0;
            channelSlotCount <= `TDMTX_COUNT_RESET;
            slotTransmitEnable <= `TDMTX_SLOT_EN_RESET;
            for (int i = 0; i < `TDMTX_CHANS; i++) begin
                chanData[i] <= 24'h000000;
            end
        end else if (apbWrite) begin
            unique case (regSel)
                4'h0: begin
                    masterMode <= pwdata[`TDMTX_CTRL_MASTER];
                    earlyFirstBit <= pwdata[`TDMTX_CTRL_EARLY];
                    syncEnable <= pwdata[`TDMTX_CTRL_SYNC_EN];
                    lowPowerDown <= pwdata[`TDMTX_CTRL_LPD];
                    ultraLowPowerDown <= pwdata[`TDMTX_CTRL_ULPD];
                end
                4'h2: begin
                    for (int i = 0; i < `TDMTX_CHANS; i++) begin
                        channelStartSlot[6*i +: 6] <= pwdata[8*i +: 6];
                        channelTransmitState[i] <= pwdata[8*i + `TDMTX_CFG_STATE_BIT];
                    end
                end
                4'h3: begin
                    for (int i = 0; i < `TDMTX_CHANS; i++) begin
                        channelSlotCount[3*i +: 3] <= pwdata[4*i +: 3];
                    end
                end
                4'h4: slotTransmitEnable[31:0] <= pwdata;
                4'h5: slotTransmitEnable[47:32] <= pwdata[15:0];
                4'h6, 4'h7, 4'h8, 4'h9: chanData[2'(regSel - 4'h6)] <= pwdata[23:0]; // [R9]
                default: ;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    // Bit clock, frame sync and sync pin cross in by two flops each
    generate
        for (genvar g = 0; g < 3; g++) begin : g_sync
            always_ff @(posedge mclk) begin
                if (!rst_b) begin
                    pinMeta[g] <= (g == 2); // Idle levels: sync line rests high
                    pinSync[g] <= (g == 2);
                end else begin
                    pinMeta[g] <= (g == 0) ? bitClkIn : ((g == 1) ? frameSyncIn : syncIn);
                    pinSync[g] <= pinMeta[g];
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // Bit clock source and edges
    // ---------------------------------------------------------------
    // Master clock runs free while powered, never gated after the data
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            divCnt <= 3'd0;
            bitClkOut <= 1'b0;
            bitClkOe <= 1'b0;
        end else begin
            bitClkOe <= masterMode;
            if (masterMode && powered) begin
                if (divCnt == 3'(`TDMTX_BCLK_HALF_CYC - 1)) begin
                    divCnt <= 3'd0;
                    bitClkOut <= ~bitClkOut; // [R2] [R22]
                end else begin
                    divCnt <= divCnt + 3'd1;
                end
            end else begin
                divCnt <= 3'd0;
                bitClkOut <= 1'b0;
            end
        end
    end

    // Slave mode moves only on edges of the incoming clock
    assign bclkLevel = masterMode ? bitClkOut : pinSync[0]; // [R1]
    assign rise = bclkLevel && !bclkPrev;
    assign fall = !bclkLevel && bclkPrev;
    assign launch = earlyFirstBit ? fall : rise; // [R21]
    assign midEdge = earlyFirstBit ? rise : fall;
    assign frameStart = rise && pinSync[1] && !fsyncPrev && powered;

    // Edge history
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            bclkPrev <= 1'b0;
            fsyncPrev <= 1'b0;
        end else begin
            bclkPrev <= bclkLevel;
            if (rise) begin
                fsyncPrev <= pinSync[1];
            end
        end
    end

    // ---------------------------------------------------------------
    // Frame shifter
    // ---------------------------------------------------------------
    tdmtx_slot_map u_map (
        .bitPos(bitPos),
        .startSlot(channelStartSlot),
        .txState(channelTransmitState),
        .slotCount(channelSlotCount),
        .sample(sample),
        .hit(mapHit),
        .bitVal(mapBit)
    );

    // Drive decision for the bit about to be launched
    always_comb begin
        next_dataOe = 1'b0;
        next_dataOut = 1'b0;
        if (bitPos < `TDMTX_WINDOW_BITS) begin
            next_dataOe = slotTransmitEnable[bitPos[8:3]] && mapHit; // [R5] [R6]
            next_dataOut = mapBit;
        end else if (!slotTransmitEnable[47]) begin
            next_dataOe = 1'b0; // [R17]
        end else if (bitPos < `TDMTX_TAIL_END) begin
            next_dataOe = 1'b1; // [R15] [R16]
            next_dataOut = mapHit && mapBit;
        end else begin
            next_dataOe = 1'b1; // Low to frame end [R15]
        end
    end

    // Whole sample caught at frame start so one frame never mixes two
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sample <= 96'h0;
        end else if (frameStart) begin
            sample <= {chanData[3], chanData[2], chanData[1], chanData[0]}; // [R24]
        end
    end

    assign nextSlot = shownPos[8:3] + 6'd1;

    // Phase, counters and the data pin
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            phase <= PH_IDLE;
            bitPos <= 11'd0;
            shownPos <= 11'd0;
            serialDataOe <= 1'b0;
            serialDataOut <= 1'b0;
        end else if (!powered) begin
            phase <= PH_IDLE;
            serialDataOe <= 1'b0;
            serialDataOut <= 1'b0;
        end else if (frameStart) begin
            phase <= PH_ARMED; // [R23]
            bitPos <= 11'd0;
        end else if (phase != PH_IDLE && launch) begin
            phase <= PH_RUN; // [R21]
            serialDataOe <= next_dataOe; // [R12]
            serialDataOut <= next_dataOut;
            shownPos <= bitPos;
            if (bitPos != 11'h7FF) begin
                bitPos <= bitPos + 11'd1;
            end
        end else if (phase == PH_RUN && midEdge && !earlyFirstBit && shownPos[2:0] == 3'd7 &&  // [R13]
                     shownPos < `TDMTX_LAST_HANDOFF && !slotTransmitEnable[nextSlot]) begin
            serialDataOe <= 1'b0; // [R14]
        end
    end

    // ---------------------------------------------------------------
    // Multichip sync
    // ---------------------------------------------------------------
    // Initiator pulls the shared line low once per enable
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            syncPhase <= SY_IDLE;
            syncCnt <= 5'd0;
            syncOe <= 1'b0;
            syncOut <= 1'b0;
        end else begin
            syncOut <= 1'b0;
            unique case (syncPhase)
                SY_IDLE: begin
                    if (syncEnable && powered) begin
                        syncPhase <= SY_PULSE;
                        syncOe <= 1'b1;
                        syncCnt <= 5'(`TDMTX_SYNC_PULSE_CYC - 1);
                    end
                end
                SY_PULSE: begin
                    if (syncCnt == 5'd0) begin
                        syncOe <= 1'b0;
                        syncPhase <= SY_HOLD;
                    end else begin
                        syncCnt <= syncCnt - 5'd1;
                    end
                end
                SY_HOLD: begin
                    if (!syncEnable) begin
                        syncPhase <= SY_IDLE;
                    end
                end
            endcase
        end
    end

    // Any powered device completing a low pulse reports done; set beats clear
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            syncLowSeen <= 1'b0;
            syncDone <= 1'b0;
        end else begin
            if (!pinSync[2] && powered) begin
                syncLowSeen <= 1'b1;
            end else if (pinSync[2]) begin
                syncLowSeen <= 1'b0;
            end
            if (pinSync[2] && syncLowSeen && powered) begin
                syncDone <= 1'b1; // [R18]
            end else if (apbWrite && regSel == 4'h1 && pwdata[`TDMTX_STAT_SYNC_DONE]) begin
                syncDone <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    a_disabled_hiz: assert property (phase == PH_RUN && shownPos < `TDMTX_WINDOW_BITS && // [R6]
        !slotTransmitEnable[shownPos[8:3]] |-> !serialDataOe) else $error("disabled slot driven");
    a_state_off: assert property (channelTransmitState == 4'h0 && shownPos < `TDMTX_WINDOW_BITS // [R4]
        |-> !serialDataOe) else $error("cleared channel placed on line");
    a_tail_low: assert property (phase == PH_RUN && shownPos >= `TDMTX_TAIL_END && // [R15]
        slotTransmitEnable[47] && powered |-> serialDataOe && !serialDataOut) else $error("tail not low");
    a_slot47_hiz: assert property (phase != PH_IDLE && launch && powered && !frameStart && // [R17]
        bitPos >= `TDMTX_WINDOW_BITS && !slotTransmitEnable[47] |=> !serialDataOe)
        else $error("slot 47 off but driven");
    a_frame_restart: assert property (frameStart |=> bitPos == 11'd0 && phase == PH_ARMED) // [R23]
        else $error("counters not restarted");
    a_first_bit: assert property (phase == PH_ARMED && launch && powered && !frameStart // [R21]
        |=> shownPos == 11'd0 && phase == PH_RUN) else $error("first bit misplaced");
    a_sample_once: assert property (frameStart |=> sample == {chanData[3], chanData[2], // [R24]
        chanData[1], chanData[0]}) else $error("sample not taken");
    a_master_clk: assert property ((masterMode && powered) [*4] |-> bitClkOut != $past(bitClkOut, 2)) // [R2]
        else $error("master bit clock stalled");
    a_early_release: assert property (phase == PH_RUN && midEdge && !earlyFirstBit && powered && // [R14]
        !frameStart && !launch && shownPos[2:0] == 3'd7 && shownPos < `TDMTX_LAST_HANDOFF &&
        !slotTransmitEnable[nextSlot] |=> !serialDataOe) else $error("no early release");
    a_sync_done: assert property (pinSync[2] && syncLowSeen && powered |=> syncDone) // [R18]
        else $error("sync done missed");

    c_frame: cover property (frameStart ##[1:100] (launch && phase == PH_RUN));
    c_tail: cover property (phase == PH_RUN && shownPos >= `TDMTX_TAIL_END && serialDataOe);
    c_sync: cover property ($rose(syncDone));
endmodule

`default_nettype wire

// ---- testbench/tdmtx_far_rx.sv ----
// Far-end TDM receiver model: bursted bit clock, frame sync and bit sampler
`default_nettype none

module tdmtx_far_rx (
    input wire logic mclk,
    input wire logic go,
    input wire logic sdOut,
    input wire logic sdOe,
    output logic bitClk,
    output logic frameSync,
    output logic got,
    output logic [1:0] bitSeen
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FrameBits = 408;
    // Half a bit clock is 5 mclk, well under the synchroniser limit
    task automatic half(input logic lvl);
        repeat (5) @(posedge mclk);
        bitClk <= lvl;
    endtask
    // One frame per go pulse; the clock stands still between frames
    initial begin
        bitClk = 0;
        frameSync = 0;
        got = 0;
        bitSeen = 0;
        forever begin
            @(posedge mclk);
            if (go) begin
                half(1'b1);
                half(1'b0);
                frameSync <= 1'b1;
                half(1'b1);
                half(1'b0);
                frameSync <= 1'b0;
                for (int r = 0; r < FrameBits; r++) begin
                    half(1'b1);
                    half(1'b0);
                    // Sample on the falling edge, well after launch and before release
                    got <= 1'b1;
                    bitSeen <= {sdOe, sdOe & sdOut};
                    @(posedge mclk) got <= 1'b0;
                end
            end
        end
    end
endmodule

`default_nettype wire

// ---- testbench/tdmtx_transmitter_tb.sv ----
// Self-checking bench for the TDM slot transmitter
`default_nettype none
`include "tdmtx_defines.svh"
`define CHK(A, E) begin check_count++; if ((A) !== (E)) begin errors++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, A, E); end end

module tdmtx_transmitter_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst_b, psel, penable, pwrite, pready, pslverr, go, got, e;
    logic bitClk, frame_sync, bcOut, bcOe, sdOut, sdOe, syOut, syOe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, cfg, cw;
    logic [1:0] seen, want;
    logic [1:0] expQ[$];
    logic [23:0] data[4];
    logic [5:0] start[4];
    logic [2:0] cnt[4];
    logic [3:0] st;
    logic [47:0] en;
    int errors = 0;
    int check_count = 0;
    int cycles = 0;
    tdmtx_transmitter u_dut (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bitClkIn(bitClk),
        .frameSyncIn(frame_sync), .syncIn(~syOe), .bitClkOut(bcOut), .bitClkOe(bcOe), .serialDataOut(sdOut),
        .serialDataOe(sdOe), .syncOut(syOut), .syncOe(syOe));
    tdmtx_far_rx u_rx (.mclk(mclk), .go(go), .sdOut(sdOut), .sdOe(sdOe), .bitClk(bitClk),
        .frameSync(frame_sync), .got(got), .bitSeen(seen));
    initial begin
        mclk = 0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic end_sim();
        $display("errors=%0d check_count=%0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Hang guard: three frames plus setup fit well inside this
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            end_sim();
        end
    end
    // -----------------------------------------------
    // APB master and expected line model
    // -----------------------------------------------
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk) penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [1:0] expBit(int k);
        int s = k / 8;
        int own = -1;
        int idx;
        if (k >= 400) return en[47] ? 2'b10 : 2'b00;
        if (!en[k < 384 ? s : 47]) return 2'b00;
        for (int c = 3; c >= 0; c--)
            if (st[c] && start[c] <= s && s < start[c] + cnt[c] && (own < 0 || start[c] >= start[own])) own = c;
        if (own < 0) return k < 384 ? 2'b00 : 2'b10;
        idx = (s - start[own]) * 8 + k % 8;
        return {1'b1, idx < 24 ? data[own][23 - idx] : 1'b0};
    endfunction
    // Oldest expected bit against each sampled bit
    always @(posedge mclk) if (got) begin
        `CHK(expQ.size() != 0, 1'b1)
        want = expQ.size() != 0 ? expQ.pop_front() : 2'h3;
        `CHK(seen, want)
    end
    initial begin
        {rst_b, psel, penable, pwrite, paddr, pwdata, go} = '0;
        void'($urandom(32'h9554A107));
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        apb(1'b0, `TDMTX_ADDR_CTRL, 32'h0);
        `CHK(rd, 32'h18)
        apb(1'b0, 12'h0FC, 32'h0);
        `CHK({e, rd}, 33'h100000000)
        // Sync enabled while still powered down: no pulse until power-up
        apb(1'b1, `TDMTX_ADDR_CTRL, 32'h1C);
        repeat (40) @(posedge mclk);
        apb(1'b0, `TDMTX_ADDR_STATUS, 32'h0);
        `CHK(rd[0], 1'b0)
        // Powered slave with sync enabled: pulse must come back as sync-done
        apb(1'b1, `TDMTX_ADDR_CTRL, 32'h4);
        repeat (40) @(posedge mclk);
        apb(1'b0, `TDMTX_ADDR_STATUS, 32'h0);
        `CHK(rd[0], 1'b1)
        start = '{6'h0, 6'h2, 6'h2, 6'h2E};
        cnt = '{3'h3, 3'h1, 3'h4, 3'h3};
        for (int f = 0; f < 3; f++) begin
            st = f == 0 ? 4'h7 : 4'hF;
            en = {f != 2, 47'h7FFF_FFFF_FFFD};
            {cfg, cw} = '0;
            if (f == 2) apb(1'b1, `TDMTX_ADDR_CTRL, 32'h6);
            for (int c = 0; c < 4; c++) begin
                data[c] = 24'($urandom);
                cfg[8*c+:8] = {1'b0, st[c], start[c]};
                cw[4*c+:4] = {1'b0, cnt[c]};
                apb(1'b1, `TDMTX_ADDR_DATA0 + 12'(4 * c), {8'h0, data[c]});
            end
            apb(1'b1, `TDMTX_ADDR_CHAN_CFG, cfg);
            apb(1'b1, `TDMTX_ADDR_SLOT_COUNT, cw);
            apb(1'b1, `TDMTX_ADDR_SLOT_EN_LO, en[31:0]);
            apb(1'b1, `TDMTX_ADDR_SLOT_EN_HI, {16'h0, en[47:32]});
            for (int k = 0; k < 408; k++) expQ.push_back(expBit(k));
            go <= 1'b1;
            @(posedge mclk) go <= 1'b0;
            wait (expQ.size() == 0);
        end
        // Master mode: generated bit clock flips every two core cycles
        apb(1'b1, `TDMTX_ADDR_CTRL, 32'h5);
        repeat (3) @(posedge mclk);
        cfg[0] = bcOut;
        repeat (2) @(posedge mclk);
        `CHK({bcOe, syOut, bcOut}, {2'b10, ~cfg[0]})
        end_sim();
    end
endmodule

`default_nettype wire
